// file: core/asf_defs.svh
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH

// ==========================================================
// register map and command byte
`define ASF_ADDR_STATUS 6'h00
`define ASF_ADDR_DATA 6'h04
`define ASF_STATUS_RESET 8'h80
`define ASF_CMD_WEN_BIT 7
`define ASF_CMD_RW_BIT 6

// ==========================================================
// result saturation values
`define ASF_RES_ALL_ONES 24'hFFFFFF
`define ASF_RES_ALL_ZERO 24'h000000

// ==========================================================
// last command bit index and serial read lengths in bits
`define ASF_CMD_LAST 6'h07
`define ASF_LEN_STATUS 6'h08
`define ASF_LEN_DATA 6'h18
`define ASF_LEN_DATA_STAT 6'h20

`endif

// file: core/asf_pkg.sv
package asf_pkg;

	// ==========================================================
	// status byte layout, bit 7 down to bit 0
	typedef struct packed {
		logic rdy;
		logic range_err;
		logic crc_err;
		logic integ_err;
		logic [1:0] rsvd;
		logic [1:0] chan;
	} asf_status_t;

	// ==========================================================
	// serial port sequencing
	typedef enum logic [1:0] {
		ASF_IDLE,
		ASF_CMD,
		ASF_READ,
		ASF_SKIP
	} asf_state_t;

endpackage : asf_pkg

// file: core/asf_pin_sync.sv
module asf_pin_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] ff1;
	logic [W-1:0] ff2;
	logic [W-1:0] ff3;
	logic [W-1:0] next_dout;

	// a bit moves only once stages two and three agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_dout[i] = (ff2[i] == ff3[i]) ? ff3[i] : dout[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ff1 <= RST_VAL;
			ff2 <= RST_VAL;
			ff3 <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			ff1 <= din;
			ff2 <= ff1;
			ff3 <= ff2;
			dout <= next_dout;
		end
	end

endmodule : asf_pin_sync

// file: core/asf_status_flags.sv
`include "asf_defs.svh"

// How it works
// - read-only status at 0x00, resets to 0x80
// - eight bits of converter and port state
// - append status after data when enabled
// - idle chip select low mirrors ready flag
// - new result written clears ready flag, except in calibration mode
// - calibration mode: calibration write clears ready
// - data register read sets ready flag
// - saturate out-of-range results, flag bit 6
// - range flag updates only on result writes
// - failed write checksum sets bit 5
// - status read clears checksum error flag
// - integrity check sets bit 4 on change
// - integrity flag cleared only by disabling check
// - bits 1:0 hold result channel index
// - channel tag latched with each result
// - command bit 7 zero, bit 6 read
module asf_status_flags import asf_pkg::*; #(
	parameter int SUM_W = 16
) (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic CS_B,
	input wire logic SCLK,
	input wire logic DIN,
	output logic DOUT,
	output logic DOUT_OE_B,
	input wire logic RESULT_WR,
	input wire logic [23:0] RESULT_RAW,
	input wire logic OVERRANGE,
	input wire logic UNDERRANGE,
	input wire logic [1:0] RESULT_CHAN,
	input wire logic CAL_MODE,
	input wire logic CAL_WR,
	input wire logic WR_CRC_FAIL,
	input wire logic DATA_STAT_EN,
	input wire logic REG_CHECK_EN,
	input wire logic [SUM_W-1:0] REG_SUM
);

	if (SUM_W < 1 || SUM_W > 32) begin : g_chk
		$error("SUM_W must be 1 to 32");
	end

	// ==========================================================
	// pin synchronisers
	logic cs_b_s;
	logic sclk_s;
	logic din_s;
	logic sclk_d;
	logic sclk_rise;
	logic sclk_fall;

	asf_pin_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.din({CS_B, SCLK, DIN}),
		.dout({cs_b_s, sclk_s, din_s})
	);

	assign sclk_rise = sclk_s & ~sclk_d;
	assign sclk_fall = ~sclk_s & sclk_d;

	// ==========================================================
	// status flags and data register
	asf_status_t flags;
	asf_status_t next_flags;
	logic [23:0] data_reg;
	logic [23:0] next_data_reg;
	logic [SUM_W-1:0] sum_ref;
	logic [SUM_W-1:0] next_sum_ref;
	logic check_en_d;
	logic rdy_clr;
	logic rd_stat_ld;
	logic rd_data_ld;

	assign rdy_clr = CAL_MODE ? CAL_WR : RESULT_WR;

	always_comb begin
		next_flags = flags;
		next_data_reg = data_reg;
		next_sum_ref = sum_ref;
		// a ready clear (a result outside calibration mode, or a calibration write in it) beats a read in the same cycle
		if (rd_data_ld) begin
			next_flags.rdy = 1'b1;
		end
		if (rdy_clr) begin
			next_flags.rdy = 1'b0;
		end
		if (RESULT_WR) begin
			if (OVERRANGE) begin
				next_data_reg = `ASF_RES_ALL_ONES;
			end else if (UNDERRANGE) begin
				next_data_reg = `ASF_RES_ALL_ZERO;
			end else begin
				next_data_reg = RESULT_RAW;
			end
			next_flags.range_err = OVERRANGE | UNDERRANGE;
			next_flags.chan = RESULT_CHAN;
		end
		if (rd_stat_ld) begin
			next_flags.crc_err = 1'b0;
		end
		if (WR_CRC_FAIL) begin
			next_flags.crc_err = 1'b1;
		end
		if (!REG_CHECK_EN) begin
			next_flags.integ_err = 1'b0;
		end else if (!check_en_d) begin
			next_sum_ref = REG_SUM; // reference taken as check is enabled
		end else if (REG_SUM != sum_ref) begin
			next_flags.integ_err = 1'b1;
		end
		next_flags.rsvd = 2'h0;
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			flags <= `ASF_STATUS_RESET;
			data_reg <= `ASF_RES_ALL_ZERO;
			sum_ref <= '0;
			check_en_d <= 1'b0;
		end else begin
			flags <= next_flags;
			data_reg <= next_data_reg;
			sum_ref <= next_sum_ref;
			check_en_d <= REG_CHECK_EN;
		end
	end

	// ==========================================================
	// serial port: command byte, then read-out
	asf_state_t st;
	asf_state_t next_st;
	logic [7:0] cmd_sh;
	logic [7:0] next_cmd_sh;
	logic [7:0] cmd_full;
	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic [5:0] rd_len;
	logic [5:0] next_rd_len;
	logic [31:0] shreg;
	logic [31:0] next_shreg;
	logic next_dout;

	assign cmd_full = {cmd_sh[6:0], din_s};

	always_comb begin
		next_st = st;
		next_cmd_sh = cmd_sh;
		next_cnt = cnt;
		next_rd_len = rd_len;
		next_shreg = shreg;
		next_dout = DOUT;
		rd_stat_ld = 1'b0;
		rd_data_ld = 1'b0;
		if (cs_b_s) begin
			next_st = ASF_IDLE;
			next_cnt = 6'h00;
			next_dout = 1'b1;
		end else begin
			case (st)
				ASF_IDLE: begin
					next_st = ASF_CMD;
					next_cnt = 6'h00;
					next_dout = flags.rdy;
				end
				ASF_CMD: begin
					if (sclk_rise) begin
						next_cmd_sh = cmd_full;
						next_cnt = cnt + 6'h01;
						if (cnt == `ASF_CMD_LAST) begin
							next_cnt = 6'h00;
							// a set enable bit is no command; keep listening
							if (cmd_full[`ASF_CMD_WEN_BIT]) begin
								next_st = ASF_CMD;
							end else if (!cmd_full[`ASF_CMD_RW_BIT]) begin
								next_st = ASF_SKIP;
							end else if (cmd_full[5:0] == `ASF_ADDR_STATUS) begin
								next_st = ASF_READ;
								rd_stat_ld = 1'b1;
								next_rd_len = `ASF_LEN_STATUS;
								next_shreg = {flags, 24'h000000};
							end else if (cmd_full[5:0] == `ASF_ADDR_DATA) begin
								next_st = ASF_READ;
								rd_data_ld = 1'b1;
								next_rd_len = DATA_STAT_EN ? `ASF_LEN_DATA_STAT
									: `ASF_LEN_DATA;
								next_shreg = {data_reg, flags};
							end else begin
								// registers outside this block read as zero
								next_st = ASF_READ;
								next_rd_len = `ASF_LEN_STATUS;
								next_shreg = 32'h00000000;
							end
						end
					end
					next_dout = flags.rdy;
				end
				ASF_READ: begin
					if (sclk_fall) begin
						if (cnt == rd_len) begin
							next_st = ASF_CMD;
							next_cnt = 6'h00;
							next_dout = flags.rdy;
						end else begin
							next_dout = shreg[31];
							next_shreg = {shreg[30:0], 1'b0};
							next_cnt = cnt + 6'h01;
						end
					end
				end
				ASF_SKIP: begin
					next_dout = flags.rdy;
				end
				default: begin
					next_st = ASF_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			st <= ASF_IDLE;
			cmd_sh <= 8'h00;
			cnt <= 6'h00;
			rd_len <= 6'h00;
			shreg <= 32'h00000000;
			sclk_d <= 1'b1;
			DOUT <= 1'b1;
			DOUT_OE_B <= 1'b1;
		end else begin
			st <= next_st;
			cmd_sh <= next_cmd_sh;
			cnt <= next_cnt;
			rd_len <= next_rd_len;
			shreg <= next_shreg;
			sclk_d <= sclk_s;
			DOUT <= next_dout;
			DOUT_OE_B <= cs_b_s;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);

	a_rdy_result: assert property (RESULT_WR && !CAL_MODE |=> !flags.rdy)
		else $error("ready not cleared by result");
	a_rdy_cal: assert property (CAL_MODE && CAL_WR |=> !flags.rdy)
		else $error("ready not cleared by calibration");
	a_rdy_read: assert property (rd_data_ld && !rdy_clr |=> flags.rdy)
		else $error("ready not set by data read");
	a_sat_over: assert property (RESULT_WR && OVERRANGE
		|=> data_reg == `ASF_RES_ALL_ONES && flags.range_err)
		else $error("overrange not saturated");
	a_sat_under: assert property (RESULT_WR && UNDERRANGE && !OVERRANGE
		|=> data_reg == `ASF_RES_ALL_ZERO && flags.range_err)
		else $error("underrange not saturated");
	a_range_hold: assert property (!RESULT_WR |=> $stable(flags.range_err))
		else $error("range flag moved without result");
	a_crc_set: assert property (WR_CRC_FAIL |=> flags.crc_err)
		else $error("checksum flag not set");
	a_crc_clear: assert property (rd_stat_ld && !WR_CRC_FAIL |=> !flags.crc_err)
		else $error("checksum flag not cleared by read");
	a_integ_set: assert property (REG_CHECK_EN && check_en_d
		&& REG_SUM != sum_ref |=> flags.integ_err [*2] or !REG_CHECK_EN)
		else $error("integrity error not flagged");
	a_integ_clear: assert property (!REG_CHECK_EN |=> !flags.integ_err)
		else $error("integrity flag survives disable");
	a_integ_sticky: assert property (flags.integ_err && REG_CHECK_EN
		|=> flags.integ_err)
		else $error("integrity flag cleared while enabled");
	a_chan_tag: assert property (RESULT_WR |=> flags.chan == $past(RESULT_CHAN))
		else $error("channel tag not latched");
	a_rsvd_zero: assert property (flags.rsvd == 2'h0)
		else $error("reserved bits set");
	a_rdy_mirror: assert property (!cs_b_s && st != ASF_READ
		|=> DOUT == $past(flags.rdy) && !DOUT_OE_B)
		else $error("ready not mirrored on data out");
	a_append_len: assert property (rd_data_ld |=> rd_len ==
		($past(DATA_STAT_EN) ? `ASF_LEN_DATA_STAT : `ASF_LEN_DATA))
		else $error("wrong data read length");

	c_stat_read: cover property (rd_stat_ld);
	c_data_append: cover property (rd_data_ld && DATA_STAT_EN);
	c_overrange: cover property (RESULT_WR && OVERRANGE);
	c_integ_err: cover property (flags.integ_err);

endmodule : asf_status_flags

// file: tb/asf_host_model.sv
// ==========
// host on the serial port, mode 3: clock idles high between frames
module asf_host_model (
	output logic cs_b,
	output logic sclk,
	output logic din,
	input wire logic clk,
	input wire logic dout_line
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_b = 1'b1;
		sclk = 1'b1;
		din = 1'b1;
	end
	// half period of 8 cycles: the pin sync needs at least 6 per half
	task automatic frame(input logic [7:0] cmd, input int n, output logic [31:0] rd);
		rd = '0;
		@(posedge clk) cs_b <= 1'b0;
		repeat (8) @(posedge clk);
		for (int i = 0; i < 8 + n; i++) begin
			sclk <= 1'b0;
			din <= (i < 8) ? cmd[7 - i] : 1'b1;
			repeat (8) @(posedge clk);
			// command bits only see the ready mirror; keep read bits alone
			if (i >= 8) begin
				rd = {rd[30:0], dout_line};
			end
			sclk <= 1'b1;
			repeat (8) @(posedge clk);
		end
		cs_b <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : frame
	task automatic peek(output logic v);
		@(posedge clk) cs_b <= 1'b0;
		repeat (8) @(posedge clk);
		v = dout_line;
		cs_b <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : peek
endmodule : asf_host_model

// file: tb/asf_status_flags_tb_top.sv
module asf_status_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic cs_b, sclk, din, dout, dout_oe_b, dout_line, v;
	logic result_wr = 1'b0;
	logic [23:0] result_raw = 24'h000000;
	logic ov = 1'b0;
	logic un = 1'b0;
	logic [1:0] result_chan = 2'h0;
	logic cal_mode = 1'b0;
	logic cal_wr = 1'b0;
	logic crc_fail = 1'b0;
	logic stat_en = 1'b0;
	logic chk_en = 1'b0;
	logic [15:0] reg_sum = 16'h1234;
	logic [31:0] rd;
	int num_errors = 0;
	int checks = 0;
	always #25 clk_sys = ~clk_sys;
	// pull-up on the shared data-out line when released
	assign dout_line = dout_oe_b ? 1'b1 : dout;
	asf_status_flags u_asf_status_flags (.CLK_SYS(clk_sys), .RST_B(rst_b), .CS_B(cs_b),
		.SCLK(sclk), .DIN(din), .DOUT(dout), .DOUT_OE_B(dout_oe_b), .RESULT_WR(result_wr),
		.RESULT_RAW(result_raw), .OVERRANGE(ov), .UNDERRANGE(un), .RESULT_CHAN(result_chan),
		.CAL_MODE(cal_mode), .CAL_WR(cal_wr), .WR_CRC_FAIL(crc_fail),
		.DATA_STAT_EN(stat_en), .REG_CHECK_EN(chk_en), .REG_SUM(reg_sum));
	asf_host_model u_asf_host_model (.clk(clk_sys), .cs_b(cs_b), .sclk(sclk), .din(din),
		.dout_line(dout_line));
	// ==========
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic st(input logic [7:0] exp);
		u_asf_host_model.frame(8'h40, 8, rd);
		chk(rd, {24'h000000, exp});
	endtask : st
	task automatic dt(input int n, input logic [31:0] exp);
		u_asf_host_model.frame(8'h44, n, rd);
		chk(rd, exp);
	endtask : dt
	task automatic wr(input logic [23:0] raw, input logic [1:0] ch, input logic o, input logic u);
		@(posedge clk_sys);
		result_wr <= 1'b1;
		result_raw <= raw;
		result_chan <= ch;
		ov <= o;
		un <= u;
		@(posedge clk_sys);
		result_wr <= 1'b0;
		ov <= 1'b0;
		un <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask : wr
	task automatic end_of_test;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	// ==========
	task automatic t_result;
		chk({31'h0, dout_oe_b}, 32'h1);
		st(8'h80);
		u_asf_host_model.peek(v);
		chk({31'h0, v}, 32'h1);
		wr(24'h55AA55, 2'h2, 1'b1, 1'b0);
		result_chan <= 2'h3;
		st(8'h42);
		u_asf_host_model.peek(v);
		chk({31'h0, v}, 32'h0);
		stat_en <= 1'b1;
		dt(32, 32'hFFFFFF42);
		stat_en <= 1'b0;
		st(8'hC2);
	endtask : t_result
	task automatic t_range;
		wr(24'h000123, 2'h3, 1'b0, 1'b1);
		dt(24, 32'h000000);
		st(8'hC3);
		wr(24'h123456, 2'h1, 1'b0, 1'b0);
		dt(24, 32'h123456);
		st(8'h81);
	endtask : t_range
	task automatic t_crc;
		@(posedge clk_sys) crc_fail <= 1'b1;
		@(posedge clk_sys) crc_fail <= 1'b0;
		st(8'hA1);
		st(8'h81);
	endtask : t_crc
	task automatic t_integ;
		chk_en <= 1'b1;
		repeat (4) @(posedge clk_sys);
		st(8'h81);
		reg_sum <= 16'h1235;
		repeat (4) @(posedge clk_sys);
		st(8'h91);
		st(8'h91);
		chk_en <= 1'b0;
		repeat (4) @(posedge clk_sys);
		st(8'h81);
	endtask : t_integ
	task automatic t_cal;
		cal_mode <= 1'b1;
		wr(24'h000010, 2'h0, 1'b0, 1'b0);
		st(8'h80);
		@(posedge clk_sys) cal_wr <= 1'b1;
		@(posedge clk_sys) cal_wr <= 1'b0;
		repeat (2) @(posedge clk_sys);
		st(8'h00);
		cal_mode <= 1'b0;
	endtask : t_cal
	// ready is low here, so a mirrored bit differs from the pull-up
	task automatic t_cmd;
		u_asf_host_model.frame(8'h01, 8, rd);
		chk(rd, 32'h00000000);
		u_asf_host_model.frame(8'hC0, 8, rd);
		chk(rd, 32'h00000000);
		dt(24, 32'h000010);
		u_asf_host_model.frame(8'h41, 8, rd);
		chk(rd, 32'h00000000);
		st(8'h80);
	endtask : t_cmd
	// ==========
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_result();
		t_range();
		t_crc();
		t_integ();
		t_cal();
		t_cmd();
		end_of_test();
	end
	// frames take 270 to 660 cycles each, some twenty of them
	initial begin
		#3_000_000;
		num_errors++;
		end_of_test();
	end
endmodule : asf_status_flags_tb_top
